// >>> sysctl_pkg.sv
// Constants, field layouts and carrier types for the CPU system control registers
package sysctl_pkg;

	// ==========================================
	// Register addresses (register addressing)
	localparam logic [7:0] ADDR_STACK_POINTER_HIGH_BYTE = 8'hd8;
	localparam logic [7:0] ADDR_STACK_POINTER_LOW_BYTE = 8'hd9;
	localparam logic [7:0] ADDR_SYSTEM_MODE = 8'hde;
	localparam logic [7:0] ADDR_STOP_GUARD = 8'hf5;

	// ==========================================
	// Field positions and values
	localparam int MODE_GLOBAL_BIT = 0;
	localparam int MODE_FAST_EN_BIT = 1;
	localparam int MODE_LEVEL_LSB = 2;
	localparam int MODE_LEVEL_MSB = 4;
	localparam logic [7:0] STOP_GUARD_PATTERN = 8'ha5;

	// ==========================================
	// Reset values
	localparam logic [7:0] STOP_GUARD_RESET = 8'h00;
	localparam logic [2:0] FAST_LEVEL_RESET = 3'h0;
	localparam logic FAST_ENABLE_RESET = 1'b0;
	localparam logic GLOBAL_ENABLE_RESET = 1'b0;
	localparam logic [7:0] READ_DATA_RESET = 8'h00;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic write;
		logic read;
		logic register_mode;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] stop_guard;
		logic [2:0] fast_level;
		logic fast_enable;
		logic global_enable;
		logic [7:0] rdata;
		logic hit;
		logic stop_enter;
		logic stop_reset;
	} ctrl_state_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} ptr_bytes_t;

endpackage

// >>> stack_pointer_bank.sv
// Two independently written stack pointer bytes, deliberately without reset
`timescale 1ns/100ps
`default_nettype none
module stack_pointer_bank
	import sysctl_pkg::*;
#(
	parameter int DATA_W = 8
) (
	input wire logic clock, // Core clock
	input wire logic clock_enable, // Freezes the bytes while low
	input wire logic write_high, // Load the high byte
	input wire logic write_low, // Load the low byte
	input wire logic [7:0] wdata, // Byte to load
	output logic [15:0] stack_pointer // High and low bytes joined
);

	// ==========================================
	// Elaboration check
	if (DATA_W != 8) begin : g_bad_width
		$error("stack_pointer_bank supports only 8-bit bytes");
	end

	// ==========================================
	// State
	ptr_bytes_t state;
	ptr_bytes_t next_state;

	always_comb begin
		next_state = state;
		if (write_high) begin
			next_state.high = wdata; // [R01] [R13]
		end
		if (write_low) begin
			next_state.low = wdata; // [R02] [R13]
		end
	end

	// No reset here: the pointer is undefined until software loads it
	always_ff @(posedge clock) begin // [R03]
		if (clock_enable) begin
			state <= next_state;
		end
	end

	assign stack_pointer = {state.high, state.low}; // [R13]

endmodule
`default_nettype wire

// >>> cpu_system_control_regs.sv
// CPU system control registers: stack pointer, stop guard and system mode
`timescale 1ns/100ps
`default_nettype none

// Operation
// [R01] The high stack pointer byte holds pointer bits 15 to 8.
// [R02] The low stack pointer byte holds pointer bits 7 to 0.
// [R03] Neither stack pointer byte is set by reset; software loads them before use.
// [R04] Stop is allowed only while the stop guard holds exactly 8'ha5.
// [R05] A stop issued without the guard pattern is skipped and a reset is raised instead.
// [R06] Software keeps bit 7 of the system mode register at zero.
// [R07] System mode bits 4 to 2 select the fast interrupt level 0 to 7.
// [R08] Fast processing applies to just the one level held in that field.
// [R09] System mode bit 1 enables fast processing for the selected level.
// [R10] System mode bit 0 is the global interrupt enable.
// [R11] After reset software turns interrupts on with the enable instruction.
// [R12] These registers are reached only through register addressing.
// [R13] Each pointer byte is written on its own and the joined pointer updates at once.
module cpu_system_control_regs
	import sysctl_pkg::*;
(
	input wire logic clock, // Core clock, 25 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic clock_enable, // Freezes all state while low and rst_n is high
	input wire reg_req_t reg_req, // Register access request
	input wire logic interrupt_enable_instruction, // Enable instruction executed
	input wire logic interrupt_disable_instruction, // Disable instruction executed
	input wire logic stop_instruction, // Stop instruction executed
	output logic [7:0] reg_rdata, // Read data, one cycle after the read
	output logic reg_hit, // Read matched a register
	output logic [15:0] stack_pointer, // Effective stack pointer
	output logic [2:0] fast_irq_level, // Level given fast processing
	output logic fast_irq_enable, // Fast processing on
	output logic global_irq_enable, // All interrupt processing allowed
	output logic stop_enter, // Pulse: enter stop
	output logic stop_reset // Pulse: guard missing, reset the chip
);

	// ==========================================
	// Decode
	function automatic logic selects(input reg_req_t req, input logic [7:0] addr);
		return req.register_mode && req.addr == addr; // [R12]
	endfunction

	logic wr_ptr_high;
	logic wr_ptr_low;
	logic wr_mode;
	logic wr_guard;
	logic guard_ok;

	assign wr_ptr_high = reg_req.write && selects(reg_req, ADDR_STACK_POINTER_HIGH_BYTE);
	assign wr_ptr_low = reg_req.write && selects(reg_req, ADDR_STACK_POINTER_LOW_BYTE);
	assign wr_mode = reg_req.write && selects(reg_req, ADDR_SYSTEM_MODE);
	assign wr_guard = reg_req.write && selects(reg_req, ADDR_STOP_GUARD);

	// ==========================================
	// Stack pointer bytes
	stack_pointer_bank #(
		.DATA_W(8)
	) u_stack (
		.clock(clock),
		.clock_enable(clock_enable),
		.write_high(wr_ptr_high),
		.write_low(wr_ptr_low),
		.wdata(reg_req.wdata),
		.stack_pointer(stack_pointer)
	);

	// ==========================================
	// Control state
	ctrl_state_t state;
	ctrl_state_t next_state;

	assign guard_ok = state.stop_guard == STOP_GUARD_PATTERN; // [R04]

	always_comb begin
		next_state = state;
		next_state.stop_enter = 1'b0;
		next_state.stop_reset = 1'b0;
		next_state.hit = 1'b0;
		next_state.rdata = READ_DATA_RESET;
		if (wr_guard) begin
			next_state.stop_guard = reg_req.wdata;
		end
		// Bit 7 is not stored, so a stray one from software has no effect
		if (wr_mode) begin // [R06]
			next_state.fast_level = reg_req.wdata[MODE_LEVEL_MSB:MODE_LEVEL_LSB]; // [R07]
			next_state.fast_enable = reg_req.wdata[MODE_FAST_EN_BIT]; // [R09]
			next_state.global_enable = reg_req.wdata[MODE_GLOBAL_BIT]; // [R10]
		end
		// Instructions act after a same-cycle write, so they win
		if (interrupt_disable_instruction) begin
			next_state.global_enable = 1'b0;
		end
		if (interrupt_enable_instruction) begin
			next_state.global_enable = 1'b1; // [R11]
		end
		if (stop_instruction) begin
			next_state.stop_enter = guard_ok; // [R04]
			next_state.stop_reset = !guard_ok; // [R05]
		end
		if (reg_req.read && reg_req.register_mode) begin // [R12]
			next_state.hit = 1'b1;
			case (reg_req.addr)
				ADDR_STACK_POINTER_HIGH_BYTE: begin
					next_state.rdata = stack_pointer[15:8]; // [R01]
				end
				ADDR_STACK_POINTER_LOW_BYTE: begin
					next_state.rdata = stack_pointer[7:0]; // [R02]
				end
				ADDR_SYSTEM_MODE: begin
					next_state.rdata = {3'h0, state.fast_level, state.fast_enable,
						state.global_enable};
				end
				ADDR_STOP_GUARD: begin
					next_state.rdata = state.stop_guard;
				end
				default: begin
					next_state.hit = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state.stop_guard <= STOP_GUARD_RESET;
			state.fast_level <= FAST_LEVEL_RESET;
			state.fast_enable <= FAST_ENABLE_RESET;
			state.global_enable <= GLOBAL_ENABLE_RESET; // [R11]
			state.rdata <= READ_DATA_RESET;
			state.hit <= 1'b0;
			state.stop_enter <= 1'b0;
			state.stop_reset <= 1'b0;
		end else if (clock_enable) begin
			state <= next_state;
		end
	end

	// ==========================================
	// Outputs
	assign reg_rdata = state.rdata;
	assign reg_hit = state.hit;
	assign fast_irq_level = state.fast_level; // [R08]
	assign fast_irq_enable = state.fast_enable;
	assign global_irq_enable = state.global_enable;
	assign stop_enter = state.stop_enter;
	assign stop_reset = state.stop_reset;

	// ==========================================
	// Assertions
	sequence guarded_stop;
		clock_enable && stop_instruction && state.stop_guard == 8'ha5;
	endsequence

	sequence unguarded_stop;
		clock_enable && stop_instruction && state.stop_guard != 8'ha5;
	endsequence

	a_stop_allowed: assert property (@(posedge clock) disable iff (!rst_n) // [R04]
		guarded_stop |=> stop_enter && !stop_reset)
		else $error("stop refused despite guard pattern");

	a_stop_reset_raised: assert property (@(posedge clock) disable iff (!rst_n) // [R05]
		unguarded_stop |=> stop_reset && !stop_enter)
		else $error("stop without guard did not raise reset");

	a_stop_enter_cause: assert property (@(posedge clock) disable iff (!rst_n) // [R04]
		$rose(stop_enter) |-> $past(stop_instruction) && $past(state.stop_guard) == 8'ha5)
		else $error("stop entered without guarded request");

	a_ptr_high_write: assert property (@(posedge clock) // [R01]
		clock_enable && wr_ptr_high |=> stack_pointer[15:8] == $past(reg_req.wdata))
		else $error("high pointer byte not loaded");

	// Only meaningful once the low byte has been loaded; it has no reset value
	a_ptr_low_keep: assert property (@(posedge clock) // [R13]
		clock_enable && wr_ptr_high && !wr_ptr_low
		|=> stack_pointer[7:0] == $past(stack_pointer[7:0]))
		else $error("low pointer byte disturbed by high write");

	a_ptr_low_write: assert property (@(posedge clock) // [R02]
		clock_enable && wr_ptr_low |=> stack_pointer[7:0] == $past(reg_req.wdata))
		else $error("low pointer byte not loaded");

	a_fast_level_write: assert property (@(posedge clock) disable iff (!rst_n) // [R07]
		clock_enable && wr_mode |=> fast_irq_level == $past(reg_req.wdata[4:2])
		&& fast_irq_enable == $past(reg_req.wdata[1]))
		else $error("fast interrupt fields not loaded");

	a_enable_instr_sets: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
		clock_enable && interrupt_enable_instruction |=> global_irq_enable)
		else $error("enable instruction did not set global enable");

	a_global_write: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
		clock_enable && wr_mode && !interrupt_enable_instruction
		&& !interrupt_disable_instruction |=> global_irq_enable == $past(reg_req.wdata[0]))
		else $error("global enable not loaded");

	a_mode_gate: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
		clock_enable && reg_req.write && !reg_req.register_mode && !stop_instruction
		|=> $stable(state.stop_guard) && $stable(fast_irq_level))
		else $error("register changed outside register addressing");

	a_hold_frozen: assert property (@(posedge clock) disable iff (!rst_n) // [R08]
		!clock_enable |=> $stable(fast_irq_level) && $stable(global_irq_enable))
		else $error("state moved while clock enable low");

	a_guard_write: assert property (@(posedge clock) disable iff (!rst_n) // [R04]
		clock_enable && wr_guard |=> state.stop_guard == $past(reg_req.wdata))
		else $error("stop guard not loaded");

	a_mode_readback: assert property (@(posedge clock) disable iff (!rst_n) // [R06]
		clock_enable && reg_req.read && selects(reg_req, ADDR_SYSTEM_MODE)
		|=> reg_hit && reg_rdata == {3'h0, $past(fast_irq_level), $past(fast_irq_enable),
		$past(global_irq_enable)})
		else $error("system mode read back wrong");

	a_miss_quiet: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
		clock_enable && reg_req.read && !reg_req.register_mode |=> !reg_hit && reg_rdata == 8'h00)
		else $error("read outside register addressing answered");

	a_stop_quiet: assert property (@(posedge clock) disable iff (!rst_n) // [R05]
		clock_enable && !stop_instruction |=> !stop_enter && !stop_reset)
		else $error("stop pulse without stop instruction");

	a_disable_clears: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
		clock_enable && interrupt_disable_instruction && !interrupt_enable_instruction
		|=> !global_irq_enable)
		else $error("disable instruction left global enable on");

endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking testbench for the CPU system control registers
`timescale 1ns/100ps
`default_nettype none
module testbench
	import sysctl_pkg::*;
;
	logic clock, rst_n, clock_enable, en_instr, dis_instr, stop_instr;
	reg_req_t req;
	logic [7:0] reg_rdata;
	logic reg_hit, fast_irq_enable, global_irq_enable, stop_enter, stop_reset;
	logic [15:0] stack_pointer;
	logic [2:0] fast_irq_level;
	int error_cnt = 0;
	int compares = 0;

	cpu_system_control_regs dut (.clock(clock), .rst_n(rst_n), .clock_enable(clock_enable),
		.reg_req(req), .interrupt_enable_instruction(en_instr),
		.interrupt_disable_instruction(dis_instr), .stop_instruction(stop_instr),
		.reg_rdata(reg_rdata), .reg_hit(reg_hit), .stack_pointer(stack_pointer),
		.fast_irq_level(fast_irq_level), .fast_irq_enable(fast_irq_enable),
		.global_irq_enable(global_irq_enable), .stop_enter(stop_enter), .stop_reset(stop_reset));

	// ==========================================
	// Shared tasks
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Inputs move 1 ns after the edge so the edge never races the driver
	task automatic bus(input logic [7:0] addr, input logic [7:0] wdata, input logic wr,
		input logic mode);
		@(posedge clock);
		#1;
		req = '{addr: addr, wdata: wdata, write: wr, read: !wr, register_mode: mode};
		@(posedge clock);
		#1;
		{req.write, req.read} = 2'b00;
	endtask

	task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic hit,
		input logic mode);
		bus(addr, 8'h00, 1'b0, mode);
		check("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
		check("reg_hit", {15'h0, hit}, {15'h0, reg_hit});
	endtask

	task automatic pulse(input logic en, input logic dis, input logic stp);
		@(posedge clock);
		#1;
		{en_instr, dis_instr, stop_instr} = {en, dis, stp};
		@(posedge clock);
		#1;
		{en_instr, dis_instr, stop_instr} = 3'b000;
	endtask

	// ==========================================
	// Scenarios
	task automatic test_reset;
		check("modes", 16'h0000, {11'h0, fast_irq_level, fast_irq_enable, global_irq_enable});
		rd(ADDR_STOP_GUARD, 8'h00, 1'b1, 1'b1);
		rd(ADDR_SYSTEM_MODE, 8'h00, 1'b1, 1'b1);
	endtask

	// Low byte first: the bytes have no reset value, so a high write must meet a loaded low
	task automatic test_stack;
		bus(ADDR_STACK_POINTER_LOW_BYTE, 8'hfe, 1'b1, 1'b1);
		check("pointer low", 16'h00fe, {8'h00, stack_pointer[7:0]});
		bus(ADDR_STACK_POINTER_HIGH_BYTE, 8'h12, 1'b1, 1'b1);
		check("pointer", 16'h12fe, stack_pointer);
		bus(ADDR_STACK_POINTER_HIGH_BYTE, 8'h80, 1'b1, 1'b1);
		check("pointer", 16'h80fe, stack_pointer);
		bus(ADDR_STACK_POINTER_LOW_BYTE, 8'h34, 1'b1, 1'b1);
		check("pointer", 16'h8034, stack_pointer);
		rd(ADDR_STACK_POINTER_HIGH_BYTE, 8'h80, 1'b1, 1'b1);
		rd(ADDR_STACK_POINTER_LOW_BYTE, 8'h34, 1'b1, 1'b1);
	endtask

	task automatic test_mode;
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			v = {3'b000, i[2:0], i[0], 1'b0};
			bus(ADDR_SYSTEM_MODE, v, 1'b1, 1'b1);
			check("fast_irq_level", {13'h0, i[2:0]}, {13'h0, fast_irq_level});
			check("fast_irq_enable", {15'h0, i[0]}, {15'h0, fast_irq_enable});
			rd(ADDR_SYSTEM_MODE, v, 1'b1, 1'b1);
		end
	endtask

	task automatic test_global;
		pulse(1'b1, 1'b0, 1'b0);
		check("global on", 16'h0001, {15'h0, global_irq_enable});
		pulse(1'b0, 1'b1, 1'b0);
		check("global off", 16'h0000, {15'h0, global_irq_enable});
		// Enable instruction beats a same-cycle clear of bit 0
		@(posedge clock);
		#1;
		req = '{addr: ADDR_SYSTEM_MODE, wdata: 8'h00, write: 1'b1, read: 1'b0, register_mode: 1'b1};
		en_instr = 1'b1;
		@(posedge clock);
		#1;
		req.write = 1'b0;
		en_instr = 1'b0;
		check("global race", 16'h0001, {15'h0, global_irq_enable});
		bus(ADDR_SYSTEM_MODE, 8'h00, 1'b1, 1'b1);
		check("global cleared", 16'h0000, {15'h0, global_irq_enable});
	endtask

	task automatic test_stop;
		logic [7:0] guards [5] = '{8'h00, 8'ha5, 8'ha4, 8'h5a, 8'ha5};
		logic ok;
		foreach (guards[k]) begin
			ok = (guards[k] == 8'b10100101);
			bus(ADDR_STOP_GUARD, guards[k], 1'b1, 1'b1);
			rd(ADDR_STOP_GUARD, guards[k], 1'b1, 1'b1);
			pulse(1'b0, 1'b0, 1'b1);
			check("stop pulses", {14'h0, ok, !ok}, {14'h0, stop_enter, stop_reset});
			@(posedge clock);
			#1;
			check("stop idle", 16'h0000, {14'h0, stop_enter, stop_reset});
		end
	endtask

	task automatic test_refused;
		bus(ADDR_STOP_GUARD, 8'h11, 1'b1, 1'b0);
		rd(ADDR_STOP_GUARD, 8'ha5, 1'b1, 1'b1);
		rd(ADDR_STOP_GUARD, 8'h00, 1'b0, 1'b0);
		bus(8'h40, 8'h33, 1'b1, 1'b1);
		rd(8'h40, 8'h00, 1'b0, 1'b1);
		@(posedge clock);
		#1;
		check("read idle", 16'h0000, {7'h0, reg_hit, reg_rdata});
	endtask

	// Guard still holds the pattern, so a leak through the enable would show as a stop
	task automatic test_freeze;
		@(posedge clock);
		#1;
		clock_enable = 1'b0;
		req = '{addr: ADDR_SYSTEM_MODE, wdata: 8'h1f, write: 1'b1, read: 1'b0, register_mode: 1'b1};
		{en_instr, stop_instr} = 2'b11;
		repeat (3) @(posedge clock);
		#1;
		check("frozen mode", 16'h0000, {11'h0, fast_irq_level, fast_irq_enable, global_irq_enable});
		check("frozen stop", 16'h0000, {14'h0, stop_enter, stop_reset});
		{req.write, en_instr, stop_instr} = 3'b000;
		clock_enable = 1'b1;
	endtask

	task automatic test_rerun;
		bus(ADDR_SYSTEM_MODE, 8'h1f, 1'b1, 1'b1);
		check("mode set", 16'h001f, {11'h0, fast_irq_level, fast_irq_enable, global_irq_enable});
		rst_n = 1'b0;
		repeat (2) @(posedge clock);
		#1;
		rst_n = 1'b1;
		test_reset();
		check("pointer kept", 16'h8034, stack_pointer);
	endtask

	// ==========================================
	// Sequence and verdict
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	initial begin
		#200us;
		error_cnt++;
		$display("ERROR watchdog expected end seen timeout");
		report_and_stop();
	end

	initial begin
		{rst_n, en_instr, dis_instr, stop_instr} = 4'h0;
		clock_enable = 1'b1;
		req = '0;
		repeat (2) @(posedge clock);
		#1;
		rst_n = 1'b1;
		test_reset();
		test_stack();
		test_mode();
		test_global();
		test_stop();
		test_refused();
		test_freeze();
		test_rerun();
		report_and_stop();
	end
endmodule
`default_nettype wire
